// ---- rtl/eew_pkg.sv ----
/*
 * eew_pkg: constants and carrier types for the data eeprom write controller.
 * assumes a 32-bit avalon-mm slave with word addressing of byte offsets.
 */
package eew_pkg;

    // -------------------------------------------------------------------
    // register map (byte offsets)
    // -------------------------------------------------------------------
    localparam logic [4:0] EEW_OFS_ADDR   = 5'h00; // eeprom_address_reg
    localparam logic [4:0] EEW_OFS_DATA   = 5'h04; // eeprom_data_reg
    localparam logic [4:0] EEW_OFS_CTRL   = 5'h08; // eeprom_control_reg
    localparam logic [4:0] EEW_OFS_UNLOCK = 5'h0C; // eeprom_unlock_reg
    localparam logic [4:0] EEW_OFS_STAT   = 5'h10; // irq status, read only
    localparam logic [4:0] EEW_OFS_CLR    = 5'h14; // irq clear, write one
    localparam logic [4:0] EEW_OFS_IEN    = 5'h18; // irq enable

    // -------------------------------------------------------------------
    // control register fields
    // -------------------------------------------------------------------
    localparam int EEW_BIT_RD    = 0; // read trigger, self clearing
    localparam int EEW_BIT_WR    = 1; // write trigger
    localparam int EEW_BIT_WALLOW = 2; // write_allow_bit
    localparam int EEW_BIT_MSEL  = 7; // memory_space_select, 1 = program
    localparam int EEW_BIT_DONE  = 0; // write_complete_flag in status

    // -------------------------------------------------------------------
    // unlock keys, reset values, timing
    // -------------------------------------------------------------------
    localparam logic [7:0]  EEW_KEY_FIRST  = 8'h55;
    localparam logic [7:0]  EEW_KEY_SECOND = 8'hAA;
    localparam logic [7:0]  EEW_RST_BYTE   = 8'h00;
    localparam logic [31:0] EEW_RD_NONE    = 32'h0000_0000;
    localparam int          EEW_CLK_MHZ    = 40;
    localparam int          EEW_WRITE_US   = 5; // nominal programming time
    localparam int          EEW_WRITE_CYC  = EEW_WRITE_US * EEW_CLK_MHZ;

    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } eew_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } eew_rsp_type;

    typedef enum logic [1:0] { EEW_LK_IDLE, EEW_LK_GOT55, EEW_LK_ARMED } eew_lock_type;

endpackage

// ---- rtl/eew_array.sv ----
/*
 * eew_array: the 256 x 8 data eeprom cell array with its programming timer.
 * assumes the controller holds address and data stable while busy is high.
 */
`timescale 1ns/10ps
module eew_array (
    input  wire logic       mclk,     // system clock
    input  wire logic       rst,      // async reset, high
    input  wire logic       start,    // one-cycle launch pulse
    input  wire logic [7:0] addr,     // byte location
    input  wire logic [7:0] wdata,    // byte to store
    output logic      [7:0] rdata,    // combinational read of addr
    output logic            busy,     // write cycle in progress
    output logic            done      // one-cycle end of write
);
    import eew_pkg::*;

    // -------------------------------------------------------------------
    // storage and timer
    // -------------------------------------------------------------------
    logic [7:0]  mem [256];
    logic [15:0] cnt_q;
    logic        busy_q;
    logic        done_q;

    assign rdata = mem[addr];
    assign busy  = busy_q;
    assign done  = done_q;

    // cells are not reset: nonvolatile contents survive reset
    always_ff @(posedge mclk) begin
        if (start)
            mem[addr] <= wdata;
    end

    // fixed-length programming interval, cannot be aborted once running
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= 16'(EEW_WRITE_CYC - 1);
            end else if (busy_q) begin
                if (cnt_q == 16'h0000) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end
endmodule // eew_array

// ---- rtl/eew_ctrl.sv ----
/*
 * eew_ctrl: register front end and unlock sequencer for data eeprom writes.
 * assumes one avalon-mm master; program-memory writes are not served here.
 */
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// - write needs 55h, AAh, then trigger
// - trigger refused unless write allowed
// - write allow changes only by software
// - running write completes despite allow clear
// - end clears trigger, sets complete flag
// - complete flag polls or interrupts
// - complete flag cleared only by software
module eew_ctrl (
    input  wire logic               mclk,      // 40 mhz system clock
    input  wire logic               rst,       // async reset, high
    input  wire eew_pkg::eew_req_type bus_req, // avalon request
    output eew_pkg::eew_rsp_type    bus_rsp,   // avalon response
    output logic                    irq        // level interrupt
);
    import eew_pkg::*;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]   addr_q;
    logic [7:0]   data_q;
    logic         wr_q;
    logic         wallow_q;
    logic         msel_q;
    logic         done_q;
    logic         ien_q;
    logic         irq_q;
    logic         wait_q;
    logic [31:0]  rdat_q;
    eew_lock_type lock_q;
    eew_lock_type lock_d;
    logic [7:0]   arr_rdata;
    logic         arr_busy;
    logic         arr_done;

    // -------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------
    function automatic logic hit(input eew_req_type r, input logic [4:0] ofs);
        return r.address == ofs;
    endfunction

    // each access takes one wait cycle, then completes
    wire acc    = (bus_req.read || bus_req.write) && wait_q;
    wire fin    = (bus_req.read || bus_req.write) && !wait_q;
    wire wr_acc = fin && bus_req.write && bus_req.byteenable[0];
    wire [7:0] wb = bus_req.writedata[7:0];

    wire w_addr   = wr_acc && hit(bus_req, EEW_OFS_ADDR);
    wire w_data   = wr_acc && hit(bus_req, EEW_OFS_DATA);
    wire w_ctrl   = wr_acc && hit(bus_req, EEW_OFS_CTRL);
    wire w_unlock = wr_acc && hit(bus_req, EEW_OFS_UNLOCK);
    wire w_clr    = wr_acc && hit(bus_req, EEW_OFS_CLR);
    wire w_ien    = wr_acc && hit(bus_req, EEW_OFS_IEN);

    // trigger accepted only when armed, allowed, idle, and pointing at data;
    // a trigger write that itself selects program memory must not touch the cells
    wire wr_req  = w_ctrl && wb[EEW_BIT_WR];
    wire launch  = wr_req && (lock_q == EEW_LK_ARMED) && wallow_q
                   && !msel_q && !wb[EEW_BIT_MSEL]
                   && !wr_q && !arr_busy;
    wire rd_req  = w_ctrl && wb[EEW_BIT_RD] && !msel_q && !arr_busy;

    wire [7:0] ctrl_view = {msel_q, 4'h0, wallow_q, wr_q, 1'b0};

    // -------------------------------------------------------------------
    // unlock tracker
    // -------------------------------------------------------------------
    always_comb begin
        lock_d = lock_q;
        if (wr_acc) begin
            case (lock_q)
                EEW_LK_IDLE:
                    lock_d = (w_unlock && wb == EEW_KEY_FIRST) ? EEW_LK_GOT55 : EEW_LK_IDLE;
                EEW_LK_GOT55:
                    lock_d = (w_unlock && wb == EEW_KEY_SECOND) ? EEW_LK_ARMED
                             : EEW_LK_IDLE;
                EEW_LK_ARMED:
                    lock_d = EEW_LK_IDLE; // one trigger per unlock
                default:
                    lock_d = EEW_LK_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            lock_q <= EEW_LK_IDLE;
        else
            lock_q <= lock_d;
    end

    // -------------------------------------------------------------------
    // software-owned registers
    // -------------------------------------------------------------------
    // address and data stay frozen while a cycle runs so it completes intact
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_q   <= EEW_RST_BYTE;
            data_q   <= EEW_RST_BYTE;
            wallow_q <= 1'b0;
            msel_q   <= 1'b0;
            ien_q    <= 1'b0;
        end else begin
            if (w_addr && !wr_q)
                addr_q <= wb;
            if (w_data && !wr_q)
                data_q <= wb;
            else if (rd_req)
                data_q <= arr_rdata;
            if (w_ctrl) begin
                wallow_q <= wb[EEW_BIT_WALLOW]; // never touched by hardware
                msel_q   <= wb[EEW_BIT_MSEL];
            end
            if (w_ien)
                ien_q <= wb[EEW_BIT_DONE];
        end
    end

    // -------------------------------------------------------------------
    // write trigger and completion flag
    // -------------------------------------------------------------------
    // trigger tracks the array, not write allow, so a clear mid-cycle is harmless
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (launch)
                wr_q <= 1'b1;
            else if (arr_done)
                wr_q <= 1'b0;
            if (arr_done)
                done_q <= 1'b1;                        // set beats clear
            else if (w_clr && wb[EEW_BIT_DONE])
                done_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // interrupt and bus response
    // -------------------------------------------------------------------
    wire [31:0] rd_mux =
        hit(bus_req, EEW_OFS_ADDR)   ? {24'h000000, addr_q}    :
        hit(bus_req, EEW_OFS_DATA)   ? {24'h000000, data_q}    :
        hit(bus_req, EEW_OFS_CTRL)   ? {24'h000000, ctrl_view} :
        hit(bus_req, EEW_OFS_STAT)   ? {31'h00000000, done_q}  : // polled view
        hit(bus_req, EEW_OFS_IEN)    ? {31'h00000000, ien_q}   :
        EEW_RD_NONE; // unlock, clear and unmapped read zero

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdat_q <= EEW_RD_NONE;
            irq_q  <= 1'b0;
        end else begin
            wait_q <= !acc;
            if (acc && bus_req.read)
                rdat_q <= rd_mux;
            irq_q <= done_q && ien_q;
        end
    end

    assign bus_rsp.waitrequest = wait_q;
    assign bus_rsp.readdata    = rdat_q;
    assign irq                 = irq_q;

    // -------------------------------------------------------------------
    // cell array
    // -------------------------------------------------------------------
    eew_array u_array (
        .mclk  (mclk),
        .rst   (rst),
        .start (launch),
        .addr  (addr_q),
        .wdata (data_q),
        .rdata (arr_rdata),
        .busy  (arr_busy),
        .done  (arr_done)
    );
endmodule // eew_ctrl

// ---- bench/eew_ctrl_assertions.sv ----
/*
 * eew_ctrl_assertions: port-level checks of the eeprom write controller.
 * assumes one avalon-mm master and byteenable kept at all ones.
 */
`timescale 1ns/10ps
module eew_ctrl_assertions
    import eew_pkg::*;
(
    input wire logic                mclk,    // system clock
    input wire logic                rst,     // async reset, high
    input wire eew_pkg::eew_req_type bus_req, // avalon request
    input wire eew_pkg::eew_rsp_type bus_rsp, // avalon response
    input wire logic                irq      // level interrupt
);
    // ---------------------------------------------------------------
    // helper: completed accesses and shadow of what software wrote
    // ---------------------------------------------------------------
    logic [1:0] lk_q;   // unlock progress as seen on the bus
    logic       allow_q;
    logic       pend_q; // a legal launch happened since trigger read 0
    wire wdone = bus_req.write && !bus_rsp.waitrequest;
    wire rdone = bus_req.read && !bus_rsp.waitrequest;
    wire is_ctrl = bus_req.address == EEW_OFS_CTRL;
    wire is_unl = bus_req.address == EEW_OFS_UNLOCK;
    wire [7:0] wd = bus_req.writedata[7:0];
    wire clrw = wdone && (bus_req.address == EEW_OFS_CLR || bus_req.address == EEW_OFS_IEN);
    wire go = wdone && is_ctrl && wd[EEW_BIT_WR] && lk_q == 2'd2 && allow_q && !wd[EEW_BIT_MSEL];
    // a 55h unlock write always restarts the tracker at step one; any other write but the next step drops it to idle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lk_q    <= 2'd0;
            allow_q <= 1'b0;
            pend_q  <= 1'b0;
        end else begin
            if (wdone) lk_q <= (is_unl && wd == EEW_KEY_FIRST) ? 2'd1 :
                (is_unl && wd == EEW_KEY_SECOND && lk_q == 2'd1) ? 2'd2 : 2'd0;
            if (wdone && is_ctrl) allow_q <= wd[EEW_BIT_WALLOW];
            if (go) pend_q <= 1'b1;
            else if (rdone && is_ctrl && !bus_rsp.readdata[EEW_BIT_WR]) pend_q <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    wait_state_a: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest
        |=> !bus_rsp.waitrequest) else $error("access not answered after one wait");
    one_cycle_a: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
        else $error("waitrequest low for more than a cycle");
    no_spurious_a: assert property ($fell(bus_rsp.waitrequest)
        |-> $past(bus_req.read || bus_req.write)) else $error("answer without a request");
    unmapped_zero_a: assert property (rdone && bus_req.address > EEW_OFS_IEN
        |-> bus_rsp.readdata == EEW_RD_NONE) else $error("unmapped read not zero");
    allow_keep_a: assert property (rdone && is_ctrl
        |-> bus_rsp.readdata[EEW_BIT_WALLOW] == allow_q)
        else $error("write allow differs from last written value");
    trig_guard_a: assert property (rdone && is_ctrl
        && bus_rsp.readdata[EEW_BIT_WR] |-> pend_q)
        else $error("trigger set without unlock and allow");
    irq_status_a: assert property (rdone && bus_req.address == EEW_OFS_STAT
        && irq && $past(irq) |-> bus_rsp.readdata[EEW_BIT_DONE])
        else $error("irq high but done flag clear");
    done_sticky_a: assert property ($fell(irq) |-> $past(clrw, 1) || $past(clrw, 2))
        else $error("irq dropped without clear or mask write");
    // ---------------------------------------------------------------
    // covers
    // ---------------------------------------------------------------
    cover property (go);
    cover property ($rose(irq));
    cover property ($fell(irq));
endmodule // eew_ctrl_assertions

bind eew_ctrl eew_ctrl_assertions u_chk (.mclk(mclk), .rst(rst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .irq(irq));

// ---- bench/eew_ctrl_tb.sv ----
/*
 * eew_ctrl_tb: directed bench for the eeprom write controller.
 * assumes the checker is bound in and the write cycle ends within 400 cycles.
 */
`timescale 1ns/10ps
module eew_ctrl_tb;
    import eew_pkg::*;
    `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
        $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
    logic              mclk;
    logic              rst;
    eew_req_type       req;
    eew_rsp_type       rsp;
    logic              irq;
    logic       [31:0] rd;
    int                n_fail;
    int                n_tests;

    eew_ctrl dut (.mclk(mclk), .rst(rst), .bus_req(req), .bus_rsp(rsp), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ---------------------------------------------------------------
    // bus tasks: hold until waitrequest sampled low, one idle edge after
    // ---------------------------------------------------------------
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        rd = rsp.readdata;
        if (n >= 50) n_fail++;
        req <= '0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rr(input logic [4:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // keys go back to back with nothing in between, as with interrupts masked
    task automatic unlock();
        wr(EEW_OFS_UNLOCK, 32'h0000_0055);
        wr(EEW_OFS_UNLOCK, 32'h0000_00AA);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0000)
        rr(EEW_OFS_STAT); `CHK(rd, 32'h0000_0000)
        wr(5'h1C, 32'h0000_00FF);
        rr(5'h1C); `CHK(rd, EEW_RD_NONE)
        $display("test reset done");
    endtask
    task automatic t_refuse();
        wr(EEW_OFS_CTRL, 32'h0000_0004);
        wr(EEW_OFS_CTRL, 32'h0000_0006);
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0004)
        wr(EEW_OFS_CTRL, 32'h0000_0000);
        unlock();
        wr(EEW_OFS_CTRL, 32'h0000_0002);
        rr(EEW_OFS_CTRL); `CHK(rd[EEW_BIT_WR], 1'b0)
        wr(EEW_OFS_CTRL, 32'h0000_0004);
        wr(EEW_OFS_UNLOCK, 32'h0000_0055);
        wr(EEW_OFS_DATA, 32'h0000_0011);
        wr(EEW_OFS_UNLOCK, 32'h0000_00AA);
        wr(EEW_OFS_CTRL, 32'h0000_0006);
        rr(EEW_OFS_CTRL); `CHK(rd[EEW_BIT_WR], 1'b0)
        unlock();
        wr(EEW_OFS_CTRL, 32'h0000_0086);
        rr(EEW_OFS_CTRL); `CHK(rd[EEW_BIT_WR], 1'b0)
        // stored select still points at program memory when the trigger comes
        unlock();
        wr(EEW_OFS_CTRL, 32'h0000_0006);
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0004)
        wr(EEW_OFS_CTRL, 32'h0000_0000); // allow kept clear when idle
        $display("test refuse done");
    endtask
    task automatic t_write();
        int n;
        wr(EEW_OFS_IEN, 32'h0000_0001);
        wr(EEW_OFS_ADDR, 32'h0000_0012); // location first
        wr(EEW_OFS_DATA, 32'h0000_005A); // then the byte
        wr(EEW_OFS_CTRL, 32'h0000_0004); // data space selected, allow set
        unlock();
        wr(EEW_OFS_CTRL, 32'h0000_0006);
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0006)
        // drop allow while the cell is still programming
        wr(EEW_OFS_CTRL, 32'h0000_0000);
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0002)
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        `CHK(irq, 1'b1)
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0000)
        idle(20);
        rr(EEW_OFS_STAT); `CHK(rd, 32'h0000_0001)
        wr(EEW_OFS_IEN, 32'h0000_0000);
        idle(2); `CHK(irq, 1'b0)
        rr(EEW_OFS_STAT); `CHK(rd, 32'h0000_0001)
        wr(EEW_OFS_IEN, 32'h0000_0001);
        idle(2); `CHK(irq, 1'b1)
        wr(EEW_OFS_CLR, 32'h0000_0001);
        idle(2); `CHK(irq, 1'b0)
        rr(EEW_OFS_STAT); `CHK(rd, 32'h0000_0000)
        // overwrite the data register so the read-back must come from the cells
        wr(EEW_OFS_DATA, 32'h0000_0000);
        wr(EEW_OFS_CTRL, 32'h0000_0001);
        rr(EEW_OFS_DATA); `CHK(rd[7:0], 8'h5A)
        // the unlock is spent: a second byte needs a fresh sequence
        wr(EEW_OFS_CTRL, 32'h0000_0004);
        wr(EEW_OFS_CTRL, 32'h0000_0006);
        rr(EEW_OFS_CTRL); `CHK(rd, 32'h0000_0004)
        $display("test write done");
    endtask
    // ---------------------------------------------------------------
    // verdict, watchdog, main sequence
    // ---------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        idle(20000);
        n_fail++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        n_fail = 0;
        n_tests = 0;
        idle(16);
        rst <= 1'b0;
        idle(1);
        t_reset();
        t_refuse();
        t_write();
        final_report();
    end
endmodule // eew_ctrl_tb
